// ==== design/fpi_pkg.sv ====
// Constants and types shared by the front panel indicator logic.
package fpi_pkg;

	// ----------------------------------------------------------------
	// Clock and blink timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 40_000_000;        // System clock rate
	localparam int unsigned BLINK_HZ        = 1;                 // Activity blink rate
	localparam int unsigned TICK_CYCLES     = CLK_HZ / (2 * BLINK_HZ); // Half blink period
	localparam int unsigned TICK_W          = 25;                // Prescaler width
	localparam int unsigned FORCE_TOGGLE_MS = 1000;              // Shutdown toggle interval
	localparam int unsigned FORCE_TOGGLE_TICKS = (FORCE_TOGGLE_MS * 2 * BLINK_HZ) / 1000;
	localparam int unsigned XV_OFF_S        = 5;                 // Auto recovery lamp delay
	localparam int unsigned XV_OFF_TICKS    = XV_OFF_S * 2 * BLINK_HZ;
	localparam int unsigned FLASH_TICKS     = 2;                 // Message flash length

	// ----------------------------------------------------------------
	// Counter widths, link indices and reset values
	// ----------------------------------------------------------------
	localparam int unsigned FLASH_W   = 2;                       // Flash counter width
	localparam int unsigned XV_W      = 4;                       // Recovery counter width
	localparam int unsigned FORCE_W   = 2;                       // Toggle counter width
	localparam int unsigned LINK_UP   = 0;                       // Upstream link index
	localparam int unsigned LINK_DN   = 1;                       // Downstream link index
	localparam logic        LAMP_RST  = 1'b0;                    // Lamps dark in reset

	// ----------------------------------------------------------------
	// Self-test sequence
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FPI_TEST_GREEN,
		FPI_TEST_RED,
		FPI_TEST_BOTH,
		FPI_TEST_RUN
	} fpi_test_t;

endpackage : fpi_pkg

// ==== design/fpi_indicator.sv ====
// Front panel lamp and auxiliary relay controller for a chained sequencer.
`timescale 1ns/10ps
// What this block does
// (RL1) Chain head blinks upstream lamp at 1 Hz
// (RL2) Last follower keeps downstream lamp dark
// (RL3) Power-up self-test cycles all lamp colours
// (RL4) Link message blinks that link lamp green
// (RL5) Retransmission blinks that link lamp red once
// (RL6) Lost link shows its lamp steady red
// (RL7) Stage lamp follows its outlet bank power
// (RL8) Forced shutdown blinks stage lamps, 1 s toggle
// (RL9) Power-down darkens stage lamps one by one
// (RL10) Stage three relay closes while lamp lit
// (RL11) Mains lamp green while unswitched power present
// (RL12) Protection lamp green while surge circuit healthy
// (RL13) Extreme-voltage lamp lights red on error
// (RL14) Auto recovery: lamp off 5 s later
// (RL15) Manual recovery: lamp held until cleared
// (RL16) Operator clear: off 2 s, then on; not timed here, the lamp drops on the xv_manual_clear_i pulse
// (RL17) Forced shutdown entry starts stage lamp blinking
// (RL18) All blink timing from one prescaled tick
// (RL19) Priority: self-test, then shutdown, then status
module fpi_indicator
	import fpi_pkg::*;
#(
	parameter int unsigned TICK_CYCLES_P = TICK_CYCLES        // Shorten for simulation
) (
	input  wire logic       sys_clk_i,                  // System clock
	input  wire logic       resetn_i,                   // Sync reset, active low
	input  wire logic       head_sel_i,                 // Chain head switch (pin)
	input  wire logic       voltage_recovery_select_i,  // 1 automatic, 0 by hand (pin)
	input  wire logic       has_downstream_i,           // A unit is linked downstream
	input  wire logic [1:0] link_msg_i,                 // Message passed pulse per link
	input  wire logic [1:0] link_retry_i,               // Retransmission pulse per link
	input  wire logic [1:0] link_lost_i,                // Communication lost per link
	input  wire logic [2:0] stage_on_i,                 // Outlet bank powered per stage
	input  wire logic       force_off_i,                // Forced shutdown active
	input  wire logic       mains_present_i,            // Unswitched outlets powered
	input  wire logic       protect_ok_i,               // Surge protection healthy
	input  wire logic       extreme_voltage_error_i,    // Line voltage out of limits
	input  wire logic       xv_manual_clear_i,          // Operator clear completed pulse
	output logic      [1:0] link_green_o,               // Link lamp green, 0 upstream
	output logic      [1:0] link_red_o,                 // Link lamp red, 0 upstream
	output logic      [2:0] stage_lamp_o,               // Stage lamps
	output logic            relay_common_contact_no_o,  // Stage three common-to-NO closed
	output logic            mains_lamp_o,               // Mains lamp green
	output logic            protect_lamp_o,             // Protection healthy lamp green
	output logic            xv_lamp_o                   // Extreme-voltage lamp red
);

	// ----------------------------------------------------------------
	// Switch synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pin_s1_q;    // First stage, read only by second
	logic [1:0] pin_s2_q;    // Safe copies of the switches
	logic [1:0] pin_raw;     // Raw switch levels
	assign pin_raw = {voltage_recovery_select_i, head_sel_i};

	// One two-flop chain per switch
	for (genvar g = 0; g < 2; g++) begin : g_sync
		always_ff @(posedge sys_clk_i) begin
			if (!resetn_i) begin
				pin_s1_q[g] <= 1'b0;
				pin_s2_q[g] <= 1'b0;
			end else begin
				pin_s1_q[g] <= pin_raw[g];
				pin_s2_q[g] <= pin_s1_q[g];
			end
		end
	end

	logic head_q;            // Unit is chain head
	logic auto_q;            // Automatic voltage recovery
	assign head_q = pin_s2_q[0];
	assign auto_q = pin_s2_q[1];

	// ----------------------------------------------------------------
	// Blink prescaler and phases
	// ----------------------------------------------------------------
	logic [TICK_W-1:0]  tick_cnt_q, tick_cnt_d;   // Cycle count within half period
	logic               tick_q, tick_d;           // One-cycle half-period pulse
	logic               blink_q, blink_d;         // 1 Hz square wave
	logic [FORCE_W-1:0] force_cnt_q, force_cnt_d; // Ticks since last toggle
	logic               force_ph_q, force_ph_d;   // Shutdown blink phase
	logic               force_seen_q, force_seen_d; // Shutdown was active

	// Single tick drives every blink, keeping all lamps in step (see RL18)
	always_comb begin
		tick_d     = 1'b0;
		tick_cnt_d = tick_cnt_q + 1'b1;
		if (tick_cnt_q == TICK_W'(TICK_CYCLES_P - 1)) begin
			tick_cnt_d = '0;
			tick_d     = 1'b1;
		end
		blink_d      = tick_q ? ~blink_q : blink_q;
		force_seen_d = force_off_i;
		force_cnt_d  = force_cnt_q;
		force_ph_d   = force_ph_q;
		// Entry restarts the phase lit so blinking shows at once (see RL17)
		if (force_off_i && !force_seen_q) begin
			force_cnt_d = '0;
			force_ph_d  = 1'b1;
		end else if (tick_q) begin
			// Toggle every 1 s worth of ticks (see RL8)
			if (force_cnt_q == FORCE_W'(FORCE_TOGGLE_TICKS - 1)) begin
				force_cnt_d = '0;
				force_ph_d  = ~force_ph_q;
			end else begin
				force_cnt_d = force_cnt_q + 1'b1;
			end
		end
	end

	// Prescaler registers
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			tick_cnt_q   <= '0;
			tick_q       <= 1'b0;
			blink_q      <= 1'b0;
			force_cnt_q  <= '0;
			force_ph_q   <= 1'b0;
			force_seen_q <= 1'b0;
		end else begin
			tick_cnt_q   <= tick_cnt_d;
			tick_q       <= tick_d;
			blink_q      <= blink_d;
			force_cnt_q  <= force_cnt_d;
			force_ph_q   <= force_ph_d;
			force_seen_q <= force_seen_d;
		end
	end

	// ----------------------------------------------------------------
	// Power-up self-test
	// ----------------------------------------------------------------
	fpi_test_t test_q, test_d;   // Self-test step
	logic      test_on;          // Self-test in progress

	// One colour step per tick, then normal display forever (see RL3)
	always_comb begin
		test_d = test_q;
		if (tick_q) begin
			unique case (test_q)
				FPI_TEST_GREEN: test_d = FPI_TEST_RED;
				FPI_TEST_RED:   test_d = FPI_TEST_BOTH;
				FPI_TEST_BOTH:  test_d = FPI_TEST_RUN;
				FPI_TEST_RUN:   test_d = FPI_TEST_RUN;
			endcase
		end
	end
	assign test_on = (test_q != FPI_TEST_RUN);

	// Self-test register
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			test_q <= FPI_TEST_GREEN;
		end else begin
			test_q <= test_d;
		end
	end

	logic tst_grn;               // Green colours lit in test
	logic tst_red;               // Red colours lit in test
	assign tst_grn = (test_q == FPI_TEST_GREEN) || (test_q == FPI_TEST_BOTH);
	assign tst_red = (test_q == FPI_TEST_RED) || (test_q == FPI_TEST_BOTH);

	// ----------------------------------------------------------------
	// Link lamps
	// ----------------------------------------------------------------
	logic [FLASH_W-1:0] msg_fl_q [2];   // Green flash time left
	logic [FLASH_W-1:0] err_fl_q [2];   // Red flash time left
	logic [FLASH_W-1:0] msg_fl_d [2];
	logic [FLASH_W-1:0] err_fl_d [2];
	logic [1:0]         lnk_grn_n;      // Normal green per link
	logic [1:0]         lnk_red_n;      // Normal red per link

	for (genvar l = 0; l < 2; l++) begin : g_link
		// Events reload the flash; a new event wins over the countdown
		always_comb begin
			msg_fl_d[l] = msg_fl_q[l];
			err_fl_d[l] = err_fl_q[l];
			if (tick_q && msg_fl_q[l] != '0) msg_fl_d[l] = msg_fl_q[l] - 1'b1;
			if (tick_q && err_fl_q[l] != '0) err_fl_d[l] = err_fl_q[l] - 1'b1;
			if (link_msg_i[l]) msg_fl_d[l] = FLASH_W'(FLASH_TICKS);    // see RL4
			if (link_retry_i[l]) err_fl_d[l] = FLASH_W'(FLASH_TICKS);  // see RL5
			// Lost link is steady red, else red flash beats green flash
			lnk_red_n[l] = link_lost_i[l] || (err_fl_q[l] != '0);       // see RL6
			lnk_grn_n[l] = !lnk_red_n[l] && (msg_fl_q[l] != '0);        // see RL4
		end

		// Flash counters
		always_ff @(posedge sys_clk_i) begin
			if (!resetn_i) begin
				msg_fl_q[l] <= '0;
				err_fl_q[l] <= '0;
			end else begin
				msg_fl_q[l] <= msg_fl_d[l];
				err_fl_q[l] <= err_fl_d[l];
			end
		end
	end

	// ----------------------------------------------------------------
	// Extreme-voltage latch
	// ----------------------------------------------------------------
	logic            xv_q, xv_d;           // Error shown
	logic [XV_W-1:0] xv_cnt_q, xv_cnt_d;   // Ticks since voltage recovered

	// Error sets and wins over any clear in the same cycle (see RL13)
	always_comb begin
		xv_d     = xv_q;
		xv_cnt_d = xv_cnt_q;
		if (extreme_voltage_error_i) begin
			xv_d     = 1'b1;
			xv_cnt_d = '0;
		end else if (xv_q && auto_q) begin
			// Tick granularity: lamp goes off 4.5 to 5 s after recovery (see RL14)
			if (tick_q) begin
				if (xv_cnt_q == XV_W'(XV_OFF_TICKS - 1)) begin
					xv_d     = 1'b0;
					xv_cnt_d = '0;
				end else begin
					xv_cnt_d = xv_cnt_q + 1'b1;
				end
			end
		end else if (xv_q && xv_manual_clear_i) begin
			// Operator sequence is timed outside this block (see RL15, RL16)
			xv_d = 1'b0;
		end
	end

	// Extreme-voltage registers
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			xv_q     <= 1'b0;
			xv_cnt_q <= '0;
		end else begin
			xv_q     <= xv_d;
			xv_cnt_q <= xv_cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Lamp selection and output registers
	// ----------------------------------------------------------------
	logic [1:0] grn_d, red_d;    // Link lamp next values
	logic [2:0] stage_d;         // Stage lamp next values
	logic       mains_d, prot_d, xv_lamp_d;

	// Self-test first, then shutdown blink, then status (see RL19)
	always_comb begin
		grn_d = lnk_grn_n;
		red_d = lnk_red_n;
		if (head_q) begin
			grn_d[LINK_UP] = blink_q;                // see RL1
			red_d[LINK_UP] = 1'b0;
		end else if (!has_downstream_i) begin
			grn_d[LINK_DN] = 1'b0;                   // see RL2
			red_d[LINK_DN] = 1'b0;
		end
		// Lamps drop one by one as banks drop (see RL7, RL9)
		stage_d    = force_off_i ? {3{force_ph_q}} : stage_on_i;   // see RL8
		mains_d    = mains_present_i;                // see RL11
		prot_d     = protect_ok_i;                   // see RL12
		xv_lamp_d  = xv_q;                           // see RL13
		if (test_on) begin
			grn_d      = {2{tst_grn}};               // see RL3
			red_d      = {2{tst_red}};
			stage_d    = {3{tst_grn}};
			mains_d    = tst_grn;
			prot_d     = tst_grn;
			xv_lamp_d  = tst_red;
		end
	end

	// Every output straight from a flop; relay mirrors stage three
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			link_green_o              <= {2{LAMP_RST}};
			link_red_o                <= {2{LAMP_RST}};
			stage_lamp_o              <= {3{LAMP_RST}};
			relay_common_contact_no_o <= LAMP_RST;
			mains_lamp_o              <= LAMP_RST;
			protect_lamp_o            <= LAMP_RST;
			xv_lamp_o                 <= LAMP_RST;
		end else begin
			link_green_o              <= grn_d;
			link_red_o                <= red_d;
			stage_lamp_o              <= stage_d;
			relay_common_contact_no_o <= stage_d[2];  // see RL10
			mains_lamp_o              <= mains_d;
			protect_lamp_o            <= prot_d;
			xv_lamp_o                 <= xv_lamp_d;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	head_blink_a: assert property (!test_on && head_q |=> link_green_o[0] == $past(blink_q)
		&& !link_red_o[0]) else $error("Head upstream lamp not following blink"); // see RL1
	dn_dark_a: assert property (!test_on && !head_q && !has_downstream_i
		|=> !link_green_o[1] && !link_red_o[1]) else $error("Last unit lamp lit"); // see RL2
	test_green_a: assert property (test_q == FPI_TEST_GREEN |=> &stage_lamp_o
		&& mains_lamp_o && !xv_lamp_o) else $error("Self-test green step wrong"); // see RL3
	retry_red_a: assert property (!test_on && !head_q && link_retry_i[0]
		|=> ##1 link_red_o[0]) else $error("Retry did not blink red"); // see RL5
	lost_red_a: assert property (!test_on && !head_q && link_lost_i[0]
		|=> link_red_o[0] && !link_green_o[0]) else $error("Lost link not red"); // see RL6
	stage_follow_a: assert property (!test_on && !force_off_i
		|=> stage_lamp_o == $past(stage_on_i)) else $error("Stage lamp mismatch"); // see RL7
	force_blink_a: assert property (!test_on && force_off_i
		|=> stage_lamp_o == {3{$past(force_ph_q)}}) else $error("Shutdown blink wrong"); // see RL8
	relay_lamp_a: assert property (relay_common_contact_no_o == stage_lamp_o[2])
		else $error("Relay does not track stage three lamp"); // see RL10
	xv_set_a: assert property (!test_on && extreme_voltage_error_i |=> xv_q ##1 xv_lamp_o)
		else $error("Extreme-voltage lamp not lit"); // see RL13
	xv_hold_a: assert property (xv_q && !auto_q && !xv_manual_clear_i |=> xv_q)
		else $error("Manual recovery lamp dropped early"); // see RL15
	tick_gap_a: assert property (tick_q |=> !tick_q)
		else $error("Prescaler tick longer than one cycle"); // see RL18

	test_done_c: cover property (test_q == FPI_TEST_BOTH ##1 test_q == FPI_TEST_RUN);
	force_c:     cover property (!test_on && $rose(force_off_i));
	xv_auto_c:   cover property (auto_q && $fell(xv_q));
	retry_c:     cover property (!test_on && link_red_o[1] && !link_lost_i[1]);

endmodule : fpi_indicator

// ==== test/fpi_lamp_panel.sv ====
// Behavioural model of the front panel lamps and stage three relay.
`timescale 1ns/10ps
module fpi_lamp_panel (
	input  wire logic       sys_clk_i,    // System clock
	input  wire logic       clr_i,        // Clear the change counter
	input  wire logic [2:0] stage_lamp_i, // Stage lamps from the controller
	input  wire logic       relay_no_i,   // Common-to-NO closed
	output logic            relay_nc_o,   // Common-to-NC closed
	output logic      [7:0] flips_o       // Stage lamp changes seen
);
	// ----------------------------------------------------------------
	// Relay and lamp watch
	// ----------------------------------------------------------------
	logic [2:0] last_q; // Lamps one edge ago

	// Break contact is the inverse of the make contact
	assign relay_nc_o = ~relay_no_i;

	// Counting changes shows blinking without sampling at the exact edge
	always_ff @(posedge sys_clk_i) begin
		last_q <= stage_lamp_i;
		if (clr_i) begin
			flips_o <= 8'h00;
		end else if (last_q !== stage_lamp_i) begin
			flips_o <= flips_o + 8'h01;
		end
	end
endmodule : fpi_lamp_panel

// ==== test/test_fpi_indicator.sv ====
// Self-checking bench for the front panel indicator controller.
`timescale 1ns/10ps
module test_fpi_indicator;
	import fpi_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int T = 8; // Short tick keeps the run brief
	logic       sys_clk_i, resetn_i, head, rsel, has_dn, force_off, mains, prot, err, mclr, clr;
	logic [1:0] msg, retry, lost, green, red;
	logic [2:0] stage_on, stage;
	logic       relay, relay_nc, mains_l, prot_l, xv_l;
	logic [7:0] flips;
	int         fails = 0, n_tests = 0, cyc_n = 0;

	fpi_indicator #(.TICK_CYCLES_P(T)) dut_u (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .head_sel_i(head),
		.voltage_recovery_select_i(rsel), .has_downstream_i(has_dn), .link_msg_i(msg),
		.link_retry_i(retry), .link_lost_i(lost), .stage_on_i(stage_on),
		.force_off_i(force_off), .mains_present_i(mains), .protect_ok_i(prot),
		.extreme_voltage_error_i(err), .xv_manual_clear_i(mclr), .link_green_o(green),
		.link_red_o(red), .stage_lamp_o(stage), .relay_common_contact_no_o(relay),
		.mains_lamp_o(mains_l), .protect_lamp_o(prot_l), .xv_lamp_o(xv_l));

	fpi_lamp_panel panel_u (.sys_clk_i(sys_clk_i), .clr_i(clr), .stage_lamp_i(stage),
		.relay_no_i(relay), .relay_nc_o(relay_nc), .flips_o(flips));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : cyc

	// Watched lamp: 0 upstream green, 1 stage one
	function automatic logic probe(input int w);
		return (w == 0) ? green[0] : stage[0];
	endfunction : probe

	// Cycles until the watched lamp changes, bounded
	task automatic run_len(input int w, output int n);
		logic v;
		v = probe(w);
		for (n = 0; n < 4 * T && probe(w) === v; n++) cyc(1);
	endtask : run_len

	task automatic close_out;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Self-test lights lamps that every input says are dark
	task automatic t_selftest;
		int i;
		cyc(3);
		resetn_i = 1'b1;
		for (i = 0; i < 4 && stage !== 3'h7; i++) cyc(1);
		chk({stage, mains_l, prot_l, relay}, 8'h3F);
		for (i = 0; i < T + 3 && red !== 2'h3; i++) cyc(1);
		chk({red, xv_l}, 8'h07);
		cyc(2 * T + 4);
		chk({stage, red, xv_l}, 8'h00);
	endtask : t_selftest

	// Steady lamps and staged power-down
	task automatic t_levels;
		int s;
		mains = 1'b1;
		prot = 1'b1;
		stage_on = 3'h7;
		cyc(3);
		chk({mains_l, prot_l, stage, relay, relay_nc}, 8'h7E);
		chk(stage, 8'h07);
		for (s = 2; s >= 0; s--) begin
			stage_on[s] = 1'b0;
			cyc(3);
			chk({stage, relay, relay_nc}, {stage_on, stage_on[2], ~stage_on[2]});
		end
		mains = 1'b0;
		prot = 1'b0;
		cyc(3);
		chk({mains_l, prot_l}, 8'h00);
	endtask : t_levels

	// Link flashes and lost-link display on a middle follower
	task automatic t_link;
		int i;
		has_dn = 1'b1;
		msg = 2'h2;
		cyc(1);
		msg = 2'h0;
		cyc(2);
		chk({green, red}, 8'h08);
		retry = 2'h3;
		cyc(1);
		retry = 2'h0;
		cyc(2);
		chk(red, 8'h03);
		for (i = 0; i < 2 * T + 3 && red !== 2'h0; i++) cyc(1);
		chk(red, 8'h00);
		lost = 2'h1;
		cyc(4 * T);
		chk(red, 8'h01);
		lost = 2'h2;
		cyc(3);
		chk(red, 8'h02);
		has_dn = 1'b0;
		msg = 2'h2;
		cyc(1);
		msg = 2'h0;
		cyc(3);
		chk({green[1], red[1]}, 8'h00);
		lost = 2'h0;
	endtask : t_link

	// Chain head activity blink, red ignored upstream
	task automatic t_head;
		int n;
		head = 1'b1;
		lost = 2'h1;
		cyc(4);
		run_len(0, n);
		run_len(0, n);
		chk(8'(n), 8'(T));
		run_len(0, n);
		chk(8'(n), 8'(T));
		chk(red[0], 1'b0);
		head = 1'b0;
		lost = 2'h0;
	endtask : t_head

	// Forced shutdown blinks stages together over their outlet state
	task automatic t_force;
		int n;
		stage_on = 3'h5;
		force_off = 1'b1;
		// Entry shows the old phase for one cycle, then all lit
		cyc(2);
		chk(stage, 8'h07);
		run_len(1, n);
		run_len(1, n);
		chk(8'(n), 8'(2 * T));
		chk(stage === 3'h7 || stage === 3'h0, 1'b1);
		chk(relay_nc ^ stage[2], 8'h01);
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		run_len(1, n);
		cyc(1);
		chk(flips, 8'h01);
		force_off = 1'b0;
		cyc(3);
		chk(stage, 8'h05);
	endtask : t_force

	// Extreme-voltage lamp, automatic then by hand
	task automatic t_xv;
		int i;
		rsel = 1'b1;
		cyc(3);
		err = 1'b1;
		cyc(2);
		chk(xv_l, 1'b1);
		err = 1'b0;
		cyc(8 * T);
		chk(xv_l, 1'b1);
		for (i = 0; i < 3 * T && xv_l !== 1'b0; i++) cyc(1);
		chk(xv_l, 1'b0);
		rsel = 1'b0;
		err = 1'b1;
		cyc(3);
		err = 1'b0;
		cyc(12 * T);
		chk(xv_l, 1'b1);
		err = 1'b1;
		mclr = 1'b1;
		cyc(1);
		mclr = 1'b0;
		cyc(2);
		chk(xv_l, 1'b1);
		err = 1'b0;
		cyc(2);
		mclr = 1'b1;
		cyc(1);
		mclr = 1'b0;
		cyc(2);
		chk(xv_l, 1'b0);
	endtask : t_xv

	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	// Whole run needs well under a thousand cycles at this tick
	always @(posedge sys_clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 5000) begin
			fails++;
			close_out();
		end
	end

	initial begin
		{resetn_i, head, rsel, has_dn, force_off, mains, prot, err, mclr, clr} = '0;
		{msg, retry, lost, stage_on} = '0;
		t_selftest();
		t_levels();
		t_link();
		t_head();
		t_force();
		t_xv();
		close_out();
	end
endmodule : test_fpi_indicator
